// ---- src/lpmc_device.sv ----
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module lpmc_device
    import lpmc_pkg::*;
#(
    parameter int OSC_START_CYCLES = OSC_START_CYC,
    parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
)(
    input wire logic clk,
    input wire logic sys_rst,
    lpmc_link.dev link,
    output logic [15:0] low_power_control_reg,
    output logic [1:0] power_mode_active
);
    if (OSC_START_CYCLES < 1 || OSC_START_CYCLES >= 2**TIMER_W ||
        PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES >= 2**TIMER_W)
    begin
        $error("lpmc_device: start or lock count out of range");
    end

    // Pins: 0 wake, 1 external reset low, 2 debugger request.
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_q;
    logic [2:0] pin_raw;
    assign pin_raw = {link.dbg_wake, ~link.external_reset_n, ~link.wake_n};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
            pin_q <= 3'h0;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int i = 0; i < 3; i++)
            begin
                if (pin_s2[i] == pin_s3[i])
                begin
                    pin_q[i] <= pin_s2[i];
                end
            end
        end
    end

    logic wake_lo;
    logic rst_lo;
    logic dbg_req;
    assign wake_lo = pin_q[0];
    assign rst_lo = pin_q[1];
    assign dbg_req = pin_q[2];

    lpmc_state_e state;
    lpmc_state_e next_state;
    logic [1:0] mode_act;
    logic [6:0] qual_cnt;
    logic [TIMER_W-1:0] timer;
    logic from_dbg;
    logic qual_done;
    logic lpm_wake;
    logic timer_done;
    logic wake_en;

    assign wake_en = low_power_control_reg[WAKE_EN_BIT];
    assign timer_done = (timer == '0);
    // Consecutive low samples reach field plus two.
    assign qual_done = wake_lo && (qual_cnt + 7'h1 ==
        {1'b0, low_power_control_reg[QUAL_MSB:QUAL_LSB]} + QUAL_EXTRA);

    always_comb
    begin
        next_state = state;
        lpm_wake = 1'b0;
        case (state)
            ST_RUN:
            begin
                if (link.idle_exec)
                begin
                    case (low_power_control_reg[MODE_MSB:MODE_LSB])
                        MODE_IDLE: next_state = ST_IDLE;
                        MODE_STBY: next_state = ST_STBY;
                        default: next_state = ST_HALT;
                    endcase
                end
            end
            ST_IDLE:
            begin
                // The CPU does the waking; nothing else happens here.
                if (rst_lo || link.wd_irq || link.any_irq ||
                    link.external_nmi)
                begin
                    next_state = ST_RUN;
                end
            end
            ST_STBY:
            begin
                if (rst_lo || dbg_req)
                begin
                    next_state = ST_RUN;
                end
                else if (link.wd_irq && wake_en)
                begin
                    next_state = ST_RUN;
                end
                else if (qual_done)
                begin
                    next_state = ST_RUN;
                    lpm_wake = 1'b1;
                end
            end
            ST_HALT:
            begin
                // Watchdog is dead here, so it is not looked at.
                if (rst_lo)
                begin
                    next_state = ST_RUN;
                end
                else if (wake_lo || dbg_req)
                begin
                    next_state = ST_OSC_UP;
                end
            end
            ST_OSC_UP:
            begin
                if (rst_lo)
                begin
                    next_state = ST_RUN;
                end
                else if (!wake_lo && !from_dbg)
                begin
                    // Wake released early: the oscillator never settled.
                    next_state = ST_HALT;
                end
                else if (timer_done)
                begin
                    next_state = ST_PLL_UP;
                end
            end
            ST_PLL_UP:
            begin
                if (rst_lo)
                begin
                    next_state = ST_RUN;
                end
                else if (timer_done)
                begin
                    next_state = ST_RUN;
                    lpm_wake = ~from_dbg;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Mode is captured at idle so later writes wait for the next one.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_act <= MODE_IDLE;
        end
        else if (state == ST_RUN && link.idle_exec)
        begin
            mode_act <= low_power_control_reg[MODE_MSB:MODE_LSB];
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            qual_cnt <= 7'h0;
        end
        else if (state == ST_STBY && wake_lo && !qual_done)
        begin
            qual_cnt <= qual_cnt + 7'h1;
        end
        else
        begin
            qual_cnt <= 7'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timer <= '0;
            from_dbg <= 1'b0;
        end
        else if (state == ST_HALT && next_state == ST_OSC_UP)
        begin
            timer <= TIMER_W'(OSC_START_CYCLES - 1);
            from_dbg <= dbg_req && !wake_lo;
        end
        else if (state == ST_OSC_UP && next_state == ST_PLL_UP)
        begin
            timer <= TIMER_W'(PLL_LOCK_CYCLES - 1);
        end
        else if (!timer_done)
        begin
            timer <= timer - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link.cpu_clock_in_en <= 1'b1;
            link.system_clock_out_en <= 1'b1;
            link.osc_en <= 1'b1;
            link.pll_en <= 1'b1;
            link.wd_alive <= 1'b1;
            link.lp_state <= ST_RUN;
        end
        else
        begin
            link.cpu_clock_in_en <= next_state == ST_RUN ||
                next_state == ST_IDLE;
            link.system_clock_out_en <= next_state == ST_RUN ||
                next_state == ST_IDLE;
            link.osc_en <= next_state != ST_HALT;
            link.pll_en <= next_state != ST_HALT &&
                next_state != ST_OSC_UP;
            link.wd_alive <= next_state == ST_RUN ||
                next_state == ST_IDLE || next_state == ST_STBY;
            link.lp_state <= next_state;
        end
    end

    // One line carries both the watchdog and the wake-up event.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link.wake_interrupt <= 1'b0;
        end
        else
        begin
            link.wake_interrupt <= lpm_wake ||
                (link.wd_irq && link.wd_alive);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            low_power_control_reg <= CTRL_RESET;
        end
        else if (link.reg_wr && link.reg_addr == CTRL_IDX)
        begin
            low_power_control_reg <= link.reg_wdata & CTRL_WMASK;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link.reg_rdata <= 16'h0000;
        end
        else if (link.reg_rd && link.reg_addr == CTRL_IDX)
        begin
            link.reg_rdata <= low_power_control_reg;
        end
        else if (link.reg_rd && link.reg_addr == STAT_IDX)
        begin
            link.reg_rdata <= {11'h000, state, mode_act};
        end
        else
        begin
            link.reg_rdata <= 16'h0000;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_mode_active <= MODE_IDLE;
        end
        else
        begin
            power_mode_active <= mode_act;
        end
    end
endmodule

// ---- src/lpmc_host.sv ----
`timescale 1ns/1ps
module lpmc_host
    import lpmc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    lpmc_link.host link,
    input wire logic [ADDR_W-1:0] sw_addr,
    input wire logic [DATA_W-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [DATA_W-1:0] sw_rdata,
    input wire logic wake_pin_n,
    input wire logic reset_pin_n,
    input wire logic debug_req,
    input wire logic watchdog_irq,
    input wire logic other_irq,
    input wire logic nmi_pin,
    input wire logic missing_clock_flag,
    output logic isr_taken
);
    logic [1:0] ctrl_mode;
    logic [7:0] irq_group1_enable;
    logic [15:0] cpu_irq_enable;
    logic global_irq_mask;
    logic idle_refused;
    logic wake_pend;
    logic hold_wake;
    logic halt_ok;
    logic do_idle;
    logic service;

    assign halt_ok = irq_group1_enable[GRP1_WAKE_BIT] &&
        cpu_irq_enable[CPU_INT1_BIT] && !missing_clock_flag;
    assign do_idle = sw_wr && sw_addr == H_CMD && sw_wdata[CMD_IDLE_BIT];
    assign service = wake_pend && link.lp_state == ST_RUN &&
        irq_group1_enable[GRP1_WAKE_BIT] && cpu_irq_enable[CPU_INT1_BIT];

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_mode <= MODE_IDLE;
            irq_group1_enable <= 8'h00;
            cpu_irq_enable <= 16'h0000;
            global_irq_mask <= 1'b1;
        end
        else if (sw_wr)
        begin
            case (sw_addr)
                H_CTRL: ctrl_mode <= sw_wdata[MODE_MSB:MODE_LSB];
                H_GRP1: irq_group1_enable <= sw_wdata[7:0];
                H_CPUIE: cpu_irq_enable <= sw_wdata;
                H_MASK: global_irq_mask <= sw_wdata[GMASK_BIT];
                default: ;
            endcase
        end
    end

    // Control writes go straight through; the device stores them.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link.reg_addr <= CTRL_IDX;
            link.reg_wdata <= 16'h0000;
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            link.idle_exec <= 1'b0;
            idle_refused <= 1'b0;
        end
        else
        begin
            link.reg_addr <= CTRL_IDX;
            link.reg_wdata <= sw_wdata;
            link.reg_wr <= sw_wr && sw_addr == H_CTRL;
            link.reg_rd <= 1'b0;
            // Limp mode or missing enables make halt unsafe.
            link.idle_exec <= do_idle && link.lp_state == ST_RUN &&
                (ctrl_mode[1] == 1'b0 || halt_ok);
            if (do_idle)
            begin
                idle_refused <= ctrl_mode[1] && !halt_ok;
            end
        end
    end

    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_s3;
    logic [4:0] pin_q;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1 <= 5'h03;
            pin_s2 <= 5'h03;
            pin_s3 <= 5'h03;
            pin_q <= 5'h03;
        end
        else
        begin
            pin_s1 <= {nmi_pin, debug_req, watchdog_irq, reset_pin_n,
                wake_pin_n};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int i = 0; i < 5; i++)
            begin
                if (pin_s2[i] == pin_s3[i])
                begin
                    pin_q[i] <= pin_s2[i];
                end
            end
        end
    end

    // Keep the wake line low until the oscillator has started.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hold_wake <= 1'b0;
        end
        else if (!pin_q[0] && (link.lp_state == ST_HALT ||
            link.lp_state == ST_OSC_UP))
        begin
            hold_wake <= 1'b1;
        end
        else if (link.lp_state == ST_PLL_UP || link.lp_state == ST_RUN)
        begin
            hold_wake <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link.wake_n <= 1'b1;
            link.external_reset_n <= 1'b1;
            link.wd_irq <= 1'b0;
            link.dbg_wake <= 1'b0;
            link.external_nmi <= 1'b0;
            link.any_irq <= 1'b0;
        end
        else
        begin
            link.wake_n <= pin_q[0] && !hold_wake;
            link.external_reset_n <= pin_q[1];
            link.wd_irq <= pin_q[2];
            link.dbg_wake <= pin_q[3];
            link.external_nmi <= pin_q[4];
            // Other sources stay quiet while halting.
            link.any_irq <= other_irq && ctrl_mode[1] == 1'b0;
        end
    end

    // Expander latch: a new event wins over the clear.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wake_pend <= 1'b0;
            isr_taken <= 1'b0;
        end
        else
        begin
            if (link.wake_interrupt)
            begin
                wake_pend <= 1'b1;
            end
            else if (service && !global_irq_mask)
            begin
                wake_pend <= 1'b0;
            end
            isr_taken <= service && !global_irq_mask;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sw_rdata <= 16'h0000;
        end
        else if (sw_rd && sw_addr == H_STAT)
        begin
            sw_rdata <= {9'h000, idle_refused, wake_pend, hold_wake,
                link.wd_alive, link.lp_state};
        end
        else
        begin
            sw_rdata <= 16'h0000;
        end
    end
endmodule

// ---- src/lpmc_link.sv ----
`timescale 1ns/1ps
interface lpmc_link;
    import lpmc_pkg::*;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic idle_exec;
    logic wake_n;
    logic external_reset_n;
    logic dbg_wake;
    logic wd_irq;
    logic any_irq;
    logic external_nmi;
    logic cpu_clock_in_en;
    logic system_clock_out_en;
    logic osc_en;
    logic pll_en;
    logic wd_alive;
    logic wake_interrupt;
    logic [2:0] lp_state;
    modport dev (
        input reg_addr, reg_wdata, reg_wr, reg_rd, idle_exec, wake_n,
        input external_reset_n, dbg_wake, wd_irq, any_irq, external_nmi,
        output reg_rdata, cpu_clock_in_en, system_clock_out_en, osc_en,
        output pll_en, wd_alive, wake_interrupt, lp_state
    );
    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd, idle_exec, wake_n,
        output external_reset_n, dbg_wake, wd_irq, any_irq, external_nmi,
        input reg_rdata, cpu_clock_in_en, system_clock_out_en, osc_en,
        input pll_en, wd_alive, wake_interrupt, lp_state
    );
endinterface

// ---- src/lpmc_pkg.sv ----
// What this block does
// - Mode 00 idle keeps all clocks running
// - Idle mode only waits for an exit
// - Mode 01 stops CPU and system clocks
// - Standby exits: reset, pin, debugger, watchdog
// - Standby wake pin low count, high restarts
// - Qualified standby wake restores clock, latches interrupt
// - Mode 1x stops oscillator, PLL and watchdog
// - Halt exits: reset, pin, debugger, never watchdog
// - Halt wake: oscillator, PLL lock, then clock
// - Wake source holds pin until oscillator up
// - Released wake pin returns to low power
// - Watchdog and wake logic share interrupt line
// - Halt needs group and CPU enables set
// - After halt, service routine unless mask set
// - No halt while missing clock flag set
// - Disable other interrupts before halt
// - Program wake enable and qualification first
// - Debug wake works with CPU clock stopped
// - Control register field layout, reserved zero
// - Qualification cycles equal field plus two
// - Mode field acts only at idle
// - Watchdog wake enable gates standby exit
package lpmc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] CTRL_IDX = 4'h0;
    localparam logic [3:0] STAT_IDX = 4'h1;
    localparam int WAKE_EN_BIT = 15;
    localparam int QUAL_LSB = 2;
    localparam int QUAL_MSB = 7;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h80ff;
    localparam logic [6:0] QUAL_EXTRA = 7'h02;
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_STBY = 2'h1;
    localparam int CLK_NS = 10;
    localparam int OSC_START_NS = 10000;
    localparam int PLL_LOCK_NS = 20000;
    localparam int OSC_START_CYC = OSC_START_NS / CLK_NS;
    localparam int PLL_LOCK_CYC = PLL_LOCK_NS / CLK_NS;
    localparam int TIMER_W = 16;
    localparam logic [3:0] H_CTRL = 4'h0;
    localparam logic [3:0] H_GRP1 = 4'h1;
    localparam logic [3:0] H_CPUIE = 4'h2;
    localparam logic [3:0] H_MASK = 4'h3;
    localparam logic [3:0] H_CMD = 4'h4;
    localparam logic [3:0] H_STAT = 4'h5;
    localparam int GRP1_WAKE_BIT = 7;
    localparam int CPU_INT1_BIT = 0;
    localparam int GMASK_BIT = 0;
    localparam int CMD_IDLE_BIT = 0;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_IDLE = 3'b001,
        ST_STBY = 3'b010,
        ST_HALT = 3'b011,
        ST_OSC_UP = 3'b100,
        ST_PLL_UP = 3'b101
    } lpmc_state_e;
endpackage

// ---- verif/lpmc_monitor.sv ----
`timescale 1ns/1ps
module lpmc_monitor
    import lpmc_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic idle_exec,
    input wire logic wake_n,
    input wire logic external_reset_n,
    input wire logic dbg_wake,
    input wire logic wd_irq,
    input wire logic cpu_clock_in_en,
    input wire logic system_clock_out_en,
    input wire logic osc_en,
    input wire logic pll_en,
    input wire logic wd_alive,
    input wire logic wake_interrupt,
    input wire logic [2:0] lp_state
);
    logic [15:0] ctrl;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] calm;
    logic [TIMER_W-1:0] pcnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl <= 16'h0000;
        else if (reg_wr && reg_addr == CTRL_IDX)
            ctrl <= reg_wdata & CTRL_WMASK;
    end
    // The lo, hi and calm counters saturate so a long sleep cannot wrap them into a check.
    // Exit events are only trusted after four calm cycles, since the
    // device may resynchronise them and act a few cycles late.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lo <= 8'h00;
            hi <= 8'h00;
            calm <= 8'h00;
            pcnt <= '0;
        end
        else
        begin
            lo <= wake_n ? 8'h00 : lo + {7'h00, lo != 8'hff};
            hi <= !wake_n ? 8'h00 : hi + {7'h00, hi != 8'hff};
            if (!external_reset_n || dbg_wake || (wd_irq && ctrl[15]))
                calm <= 8'h00;
            else
                calm <= calm + {7'h00, calm != 8'hff};
            pcnt <= (lp_state == ST_PLL_UP) ? pcnt + 1'b1 : '0;
        end
    end
    a_idle_clocks: assert property (lp_state == ST_IDLE |->
        cpu_clock_in_en && system_clock_out_en && osc_en)
        else $error("clock stopped in idle");
    a_stby_clocks: assert property (lp_state == ST_STBY |->
        !cpu_clock_in_en && !system_clock_out_en && osc_en && pll_en
        && wd_alive)
        else $error("wrong clocks in standby");
    a_halt_clocks: assert property (lp_state == ST_HALT |->
        !cpu_clock_in_en && !system_clock_out_en && !osc_en && !pll_en
        && !wd_alive)
        else $error("clock running in halt");
    a_run_hold: assert property (lp_state == ST_RUN && !idle_exec
        |=> lp_state == ST_RUN)
        else $error("left run without idle");
    a_entry_mode: assert property (lp_state == ST_RUN && idle_exec
        |=> lp_state == (ctrl[1] ? ST_HALT : ctrl[0] ? ST_STBY : ST_IDLE))
        else $error("wrong mode entered at idle");
    a_halt_stay: assert property (lp_state == ST_HALT && calm >= 4
        && hi >= 4 |=> lp_state == ST_HALT)
        else $error("halt left without wake event");
    // The enabled watchdog wakes standby unsynchronised, at once.
    a_qual_min: assert property (lp_state == ST_STBY && calm >= 4
        && !(wd_irq && ctrl[15]) && lo <= {2'b00, ctrl[7:2]}
        |=> lp_state == ST_STBY)
        else $error("standby left before qualification");
    a_pll_len: assert property (lp_state == ST_PLL_UP
        && external_reset_n |=> (lp_state == ST_RUN) ==
        ($past(pcnt) == PLL_LOCK_CYCLES - 1))
        else $error("pll wait length wrong");
    a_wint_src: assert property (wake_interrupt |-> wd_irq ||
        $past(wd_irq) || $past(wd_irq, 2) ||
        lp_state inside {ST_STBY, ST_PLL_UP, ST_RUN} &&
        $past(lp_state) inside {ST_STBY, ST_PLL_UP})
        else $error("wake interrupt without cause");
endmodule

// ---- verif/test_low_power_mode_control.sv ----
`timescale 1ns/1ps
module test_low_power_mode_control
    import lpmc_pkg::*;
;
    logic clk, sys_rst, sw_wr, sw_rd, isr_taken;
    logic wake_pin_n, reset_pin_n, debug_req, watchdog_irq;
    logic other_irq, nmi_pin, missing_clock_flag;
    logic [3:0] sw_addr;
    logic [15:0] sw_wdata, sw_rdata, ctrl_q, m_ctrl, v;
    logic [1:0] mode_q;
    logic [5:0] q;
    int n_errors = 0, n_compared = 0, isr_cnt = 0, exp_isr, k;
    lpmc_link lnk ();
    lpmc_device #(.OSC_START_CYCLES(4), .PLL_LOCK_CYCLES(6))
        lpmc_device_inst (.clk(clk), .sys_rst(sys_rst), .link(lnk),
        .low_power_control_reg(ctrl_q), .power_mode_active(mode_q));
    lpmc_host lpmc_host_inst (.clk(clk), .sys_rst(sys_rst), .link(lnk),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .wake_pin_n(wake_pin_n),
        .reset_pin_n(reset_pin_n), .debug_req(debug_req),
        .watchdog_irq(watchdog_irq), .other_irq(other_irq),
        .nmi_pin(nmi_pin), .missing_clock_flag(missing_clock_flag),
        .isr_taken(isr_taken));
    lpmc_monitor #(.PLL_LOCK_CYCLES(6)) lpmc_monitor_inst (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(lnk.reg_addr),
        .reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr),
        .idle_exec(lnk.idle_exec), .wake_n(lnk.wake_n),
        .external_reset_n(lnk.external_reset_n), .dbg_wake(lnk.dbg_wake),
        .wd_irq(lnk.wd_irq), .cpu_clock_in_en(lnk.cpu_clock_in_en),
        .system_clock_out_en(lnk.system_clock_out_en), .osc_en(lnk.osc_en),
        .pll_en(lnk.pll_en), .wd_alive(lnk.wd_alive),
        .wake_interrupt(lnk.wake_interrupt), .lp_state(lnk.lp_state));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (isr_taken === 1'b1)
            isr_cnt++;
    task automatic print_verdict();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", s, e, g);
            n_errors++;
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        v = sw_rdata;
    endtask
    task automatic ev(input int i, input logic b);
        @(posedge clk);
        case (i)
            0: debug_req <= b;
            1: watchdog_irq <= b;
            2: reset_pin_n <= !b;
            3: other_irq <= b;
            default: nmi_pin <= b;
        endcase
    endtask
    task automatic waitst(input logic [2:0] s, input int lim);
        k = 0;
        @(negedge clk);
        while (lnk.lp_state !== s && k < lim)
        begin
            @(negedge clk);
            k++;
        end
        chk("lp_state", 16'(s), 16'(lnk.lp_state));
    endtask
    task automatic sleep(input logic [15:0] c, input logic [2:0] s);
        wr(H_CTRL, c);
        wr(H_CMD, 16'h0001);
        waitst(s, 8);
    endtask
    // The run needs well under 1000 cycles; this limit only catches a hang.
    initial
    begin
        #300000;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        sys_rst = 1'b1;
        {sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
        {wake_pin_n, reset_pin_n} = 2'b11;
        {debug_req, watchdog_irq, other_irq, nmi_pin} = 4'h0;
        missing_clock_flag = 1'b0;
        void'($urandom(32'h1fcf1a67));
        hold(3);
        sys_rst <= 1'b0;
        hold(5);
        chk("ctrl", CTRL_RESET, ctrl_q);
        wr(H_CTRL, 16'hffff);
        hold(3);
        chk("ctrl", 16'h80ff, ctrl_q);
        rd(H_STAT);
        chk("stat", 16'(ST_RUN), v & 16'h0007);
        rd(4'hf);
        chk("unmapped", 16'h0000, v);
        wr(H_GRP1, 16'h0080);
        wr(H_CPUIE, 16'h0001);
        wr(H_MASK, 16'h0000);
        for (int i = 1; i < 5; i++)
        begin
            sleep(16'h0000, ST_IDLE);
            ev(i, 1'b1);
            waitst(ST_RUN, 20);
            ev(i, 1'b0);
            hold(6);
        end
        q = 6'($urandom_range(0, 20));
        m_ctrl = {8'h00, q, 2'b01};
        sleep(m_ctrl, ST_STBY);
        wr(H_CTRL, m_ctrl | 16'h0002);
        hold(3);
        chk("ctrl", m_ctrl | 16'h0002, ctrl_q);
        chk("mode", 16'h0001, 16'(mode_q));
        ev(1, 1'b1);
        hold(10);
        waitst(ST_STBY, 0);
        ev(1, 1'b0);
        @(posedge clk) wake_pin_n <= 1'b0;
        hold(q + 1);
        wake_pin_n <= 1'b1;
        hold(10);
        waitst(ST_STBY, 0);
        // The watchdog pulse above still sits in the shared latch, so
        // the wake pulse lands while it is served and is served again.
        exp_isr = isr_cnt + 2;
        @(posedge clk) wake_pin_n <= 1'b0;
        waitst(ST_RUN, 90);
        chk("qual", 16'h1, 16'(k > q + 1 && k < q + 12));
        @(posedge clk) wake_pin_n <= 1'b1;
        hold(8);
        chk("isr", 16'(exp_isr), 16'(isr_cnt));
        for (int i = 0; i < 3; i++)
        begin
            sleep(16'h8001, ST_STBY);
            ev(i, 1'b1);
            waitst(ST_RUN, 20);
            ev(i, 1'b0);
            hold(6);
        end
        // Both encodings of the top mode bit, with the mask clear then set.
        for (int i = 0; i < 2; i++)
        begin
            wr(H_MASK, 16'(i));
            exp_isr = isr_cnt + 1 - i;
            sleep(16'h0002 | 16'(i), ST_HALT);
            ev(1, 1'b1);
            hold(10);
            waitst(ST_HALT, 0);
            ev(1, 1'b0);
            @(posedge clk) wake_pin_n <= 1'b0;
            waitst(ST_PLL_UP, 40);
            waitst(ST_RUN, 20);
            @(posedge clk) wake_pin_n <= 1'b1;
            hold(8);
            chk("isr", 16'(exp_isr), 16'(isr_cnt));
        end
        sleep(16'h0002, ST_HALT);
        ev(0, 1'b1);
        waitst(ST_RUN, 40);
        ev(0, 1'b0);
        @(posedge clk) missing_clock_flag <= 1'b1;
        wr(H_CMD, 16'h0001);
        hold(4);
        waitst(ST_RUN, 0);
        rd(H_STAT);
        chk("refused", 16'h1, 16'(v[6]));
        @(posedge clk) missing_clock_flag <= 1'b0;
        wr(H_GRP1, 16'h0000);
        wr(H_CMD, 16'h0001);
        hold(4);
        waitst(ST_RUN, 0);
        print_verdict();
    end
endmodule
